//--- hdl/ulp_mode_control.sv
// Low-power mode control with wake-source capture, APB registers and an interrupt.
// Assumes pins and event inputs are synchronous to pclk; a single clock domain.
//
// Notes on behaviour
// - Upper five bits of wake_source_status read zero, writes ignored.
// - Port-match wake detection active in low power when its enable bit is set.
// - Rising edge on power-down or slave-select pin enters low power.
// - Falling edge on either pin wakes, regulator back on.
// - Port-match enable bit self-clears on wake-up.
// - Wake cause reported in status: alarm, oscillator failure, port match.
// - Status bit 2 set when last wake was oscillator failure.
// - Status bit 1 set when last wake was clock alarm.
// - Status bit 0 set when last wake was port match.
// - All status bits zero after wake means a pin falling edge woke it.
// - Writing one to master_control status-clear bit clears wake status.
// - One common polarity for all pins; level-sensitive match every cycle.
// - Mask bit 0 blocks a pin's port match, 1 allows it.
// - Entry refused while a wake event is pending; interrupt stays asserted.
// - Oscillator disabled means no alarm or oscillator-failure wake-ups.
`timescale 1ns/1ns
`default_nettype none
module ulp_mode_control
  import ulp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ulp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down_pin,
  input wire logic slave_select_pin,
  input wire logic alarm_event,
  input wire logic osc_fail_event,
  input wire logic [ulp_pkg::PM_PINS-1:0] port_pins,
  output logic regulator_enable,
  output logic low_power_mode,
  output logic irq
);
  import ulp_pkg::*;

  power_state_e state_q;
  logic [7:0] lpc_q;
  logic [2:0] wake_status_q;
  logic [PM_PINS-1:0] pm_mask_q;
  logic [IRQ_W-1:0] int_status_q;
  logic [IRQ_W-1:0] int_mask_q;
  logic pwr_prev_q;
  logic nss_prev_q;
  logic [31:0] prdata_q;
  logic [9:0] reg_idx;
  logic wr_access;
  logic setup_phase;
  logic mapped;
  logic pin_rise;
  logic pin_fall;
  logic alarm_hit;
  logic fail_hit;
  logic pm_hit;
  logic pending;
  logic wake_now;
  logic enter_now;
  logic refuse_now;
  logic status_clear;
  logic [2:0] wake_cause;
  logic [IRQ_W-1:0] int_set;
  logic [31:0] rd_mux;

  // Bus decode; the slave never stalls, so each transfer ends in its access cycle
  assign reg_idx = paddr[ADDR_W-1:2];
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign pready = 1'b1;
  assign mapped = (reg_idx == IDX_WAKE_STATUS) || (reg_idx == IDX_LP_CONTROL)
               || (reg_idx == IDX_MASTER_CONTROL) || (reg_idx == IDX_PM_MASK)
               || (reg_idx == IDX_INT_STATUS) || (reg_idx == IDX_INT_MASK);
  assign pslverr = psel && penable && !mapped;

  // Pin edges against last cycle; both pins act alike
  assign pin_rise = (power_down_pin && !pwr_prev_q) || (slave_select_pin && !nss_prev_q);
  assign pin_fall = (!power_down_pin && pwr_prev_q) || (!slave_select_pin && nss_prev_q);

  // Wake sources while in low power; oscillator sources vanish when disabled
  assign alarm_hit = alarm_event && !lpc_q[LPC_RTC_DISABLE];
  assign fail_hit = osc_fail_event && !lpc_q[LPC_RTC_DISABLE];
  // Polarity 0 matches a high level, 1 a low level, on every unmasked pin
  assign pm_hit = lpc_q[LPC_PM_ENABLE]
               && |(pm_mask_q & (port_pins ^ {PM_PINS{lpc_q[LPC_POLARITY]}}));
  assign wake_cause = {fail_hit, alarm_hit, pm_hit};

  // A pending interrupt blocks entry, so the host can see the refusal on irq
  assign pending = irq;
  assign enter_now = (state_q == ST_NORMAL) && pin_rise && !pending;
  assign refuse_now = (state_q == ST_NORMAL) && pin_rise && pending;
  assign wake_now = (state_q == ST_LOWPOWER) && (pin_fall || |wake_cause);

  assign status_clear = wr_access && (reg_idx == IDX_MASTER_CONTROL)
                     && pwdata[MC_STATUS_CLEAR];

  // Pin history; reset high so a pin already high at reset is not an entry edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr_prev_q <= 1'b1;
      nss_prev_q <= 1'b1;
    end
    else
    begin
      pwr_prev_q <= power_down_pin;
      nss_prev_q <= slave_select_pin;
    end
  end

  // Power state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_NORMAL;
    end
    else
    begin
      unique case (state_q)
        ST_NORMAL:
        begin
          if (enter_now)
          begin
            state_q <= ST_LOWPOWER;
          end
        end
        ST_LOWPOWER:
        begin
          if (wake_now)
          begin
            state_q <= ST_NORMAL;
          end
        end
      endcase
    end
  end

  assign low_power_mode = (state_q == ST_LOWPOWER);
  assign regulator_enable = (state_q == ST_NORMAL);

  // Control register; wake-up self-clears the port-match enable and wins over a write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lpc_q <= LPC_RESET;
    end
    else
    begin
      if (wr_access && (reg_idx == IDX_LP_CONTROL))
      begin
        lpc_q <= pwdata[7:0] & LPC_WRITE_MASK;
      end
      if (wake_now)
      begin
        lpc_q[LPC_PM_ENABLE] <= 1'b0;
      end
    end
  end

  // Wake-source status; capture at wake wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_status_q <= WS_RESET;
    end
    else if (wake_now)
    begin
      wake_status_q <= wake_cause;
    end
    else if (status_clear)
    begin
      wake_status_q <= WS_RESET;
    end
  end

  // Per-pin mask; the master control reset action zeroes every mask bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pm_mask_q <= PM_MASK_RESET;
    end
    else if (wr_access && (reg_idx == IDX_MASTER_CONTROL) && pwdata[MC_MASK_RESET])
    begin
      pm_mask_q <= PM_MASK_RESET;
    end
    else if (wr_access && (reg_idx == IDX_PM_MASK))
    begin
      pm_mask_q <= pwdata[PM_PINS-1:0];
    end
  end

  // Interrupt status: sticky, write one to clear, a new event wins over its clear
  assign int_set = {refuse_now, wake_now};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_status_q <= IRQ_RESET;
    end
    else
    begin
      if (wr_access && (reg_idx == IDX_INT_STATUS))
      begin
        int_status_q <= (int_status_q & ~pwdata[IRQ_W-1:0]) | int_set;
      end
      else
      begin
        int_status_q <= int_status_q | int_set;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_mask_q <= IRQ_RESET;
    end
    else if (wr_access && (reg_idx == IDX_INT_MASK))
    begin
      int_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(int_status_q & int_mask_q);

  // Read mux; unused and action bits read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (reg_idx)
      IDX_WAKE_STATUS: rd_mux = {29'h0000_0000, wake_status_q};
      IDX_LP_CONTROL: rd_mux = {24'h00_0000, lpc_q};
      IDX_PM_MASK: rd_mux = {24'h00_0000, pm_mask_q};
      IDX_INT_STATUS: rd_mux = {30'h0000_0000, int_status_q};
      IDX_INT_MASK: rd_mux = {30'h0000_0000, int_mask_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is latched in the setup cycle so it stands from a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (setup_phase && !pwrite)
    begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata = prdata_q;

  // Checks
  sequence s_rise_clean;
    (state_q == ST_NORMAL) && pin_rise && !irq;
  endsequence

  sequence s_in_lowpower;
    state_q == ST_LOWPOWER;
  endsequence

  chk_enter_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
    s_rise_clean |=> s_in_lowpower ##0 !regulator_enable)
    else $error("Rising pin edge did not enter low power");

  chk_wake_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
    s_in_lowpower ##0 pin_fall |=> (state_q == ST_NORMAL) && regulator_enable)
    else $error("Falling pin edge did not wake the device");

  chk_refuse_pending: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_NORMAL) && pin_rise && irq |=> (state_q == ST_NORMAL) && irq)
    else $error("Entry taken while a wake event was pending");

  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && (reg_idx == IDX_WAKE_STATUS) |-> prdata[31:3] == 29'h0)
    else $error("Wake status read showed a set upper bit");

  chk_pm_selfclear: assert property (@(posedge pclk) disable iff (!presetn)
    wake_now |=> !lpc_q[LPC_PM_ENABLE])
    else $error("Port-match enable not cleared on wake");

  chk_cause_capture: assert property (@(posedge pclk) disable iff (!presetn)
    wake_now |=> wake_status_q == $past(wake_cause))
    else $error("Wake cause not captured");

  chk_pin_wake_zero: assert property (@(posedge pclk) disable iff (!presetn)
    wake_now && !alarm_event && !osc_fail_event && !pm_hit |=> wake_status_q == 3'h0)
    else $error("Pin wake left a status bit set");

  chk_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
    status_clear && !wake_now |=> wake_status_q == 3'h0)
    else $error("Status clear did not clear wake status");

  chk_rtc_gated: assert property (@(posedge pclk) disable iff (!presetn)
    lpc_q[LPC_RTC_DISABLE] ##0 s_in_lowpower ##0 !pin_fall && !pm_hit |=> s_in_lowpower)
    else $error("Disabled oscillator sources woke the device");

  chk_pm_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    s_in_lowpower ##0 lpc_q[LPC_PM_ENABLE]
      && (lpc_q[LPC_POLARITY] ? |(pm_mask_q & ~port_pins) : |(pm_mask_q & port_pins))
      |=> (state_q == ST_NORMAL))
    else $error("Matching unmasked pin did not wake");

  chk_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    pm_mask_q == 8'h00 |-> !pm_hit)
    else $error("Masked pins raised a port match");

  chk_pm_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !lpc_q[LPC_PM_ENABLE] |-> !pm_hit)
    else $error("Port match active with enable cleared");

  chk_alarm_bit: assert property (@(posedge pclk) disable iff (!presetn)
    wake_now && alarm_hit |=> wake_status_q[WS_ALARM])
    else $error("Alarm wake not reported");

  chk_fail_bit: assert property (@(posedge pclk) disable iff (!presetn)
    wake_now && fail_hit |=> wake_status_q[WS_OSC_FAIL])
    else $error("Oscillator failure wake not reported");

  chk_pm_bit: assert property (@(posedge pclk) disable iff (!presetn)
    wake_now && pm_hit |=> wake_status_q[WS_PORTMATCH])
    else $error("Port-match wake not reported");

  chk_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wake_now && !status_clear |=> $stable(wake_status_q))
    else $error("Wake status changed without cause");
endmodule
`default_nettype wire

//--- hdl/ulp_pkg.sv
// Constants for the low-power mode control and wake-source status block.
// Assumes a 32-bit APB slave where each register index maps to byte address index*4.
package ulp_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_WAKE_STATUS = 10'h042;
  localparam logic [9:0] IDX_LP_CONTROL = 10'h0A2;
  localparam logic [9:0] IDX_MASTER_CONTROL = 10'h0A0;
  localparam logic [9:0] IDX_PM_MASK = 10'h0C0;
  localparam logic [9:0] IDX_INT_STATUS = 10'h0C1;
  localparam logic [9:0] IDX_INT_MASK = 10'h0C2;
  localparam int ADDR_W = 12;
  localparam int PM_PINS = 8;
  // Field positions in low_power_control
  localparam int LPC_POLARITY = 0;
  localparam int LPC_PM_ENABLE = 1;
  localparam int LPC_DISPLAY_LP = 3;
  localparam int LPC_RTC_DISABLE = 4;
  localparam logic [7:0] LPC_WRITE_MASK = 8'h1B;
  localparam logic [7:0] LPC_RESET = 8'h00;
  // Field positions in wake_source_status
  localparam int WS_PORTMATCH = 0;
  localparam int WS_ALARM = 1;
  localparam int WS_OSC_FAIL = 2;
  localparam logic [2:0] WS_RESET = 3'h0;
  // Field positions in master_control (action bits only)
  localparam int MC_MASK_RESET = 1;
  localparam int MC_STATUS_CLEAR = 6;
  // Interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  localparam logic [PM_PINS-1:0] PM_MASK_RESET = 8'h00;
  typedef enum logic [0:0] {ST_NORMAL, ST_LOWPOWER} power_state_e;
endpackage

//--- sim/tb_ulp_mode_control.sv
// Testbench for ulp_mode_control: a table of wake cases, then hand tests.
// Assumes ulp_host_model drives the pins and pclk runs at 100 MHz.
`timescale 1ns/1ns
`default_nettype none
module tb_ulp_mode_control;
  import ulp_pkg::*;
  typedef struct packed {
    logic pol, en, dis, ss;
    logic [7:0] mask, pins;
    logic al, of;
    logic [2:0] exp;
  } row_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, rerr, pd_pin, ss_pin, reg_en, lp_mode, irq;
  logic sleep_req = 0, use_ss = 0, alarm = 0, osc = 0;
  logic [7:0] pins = '0, idle;
  int fail_count = 0, checks = 0;
  row_s rows [8];
  row_s r;

  ulp_host_model ulp_host_model_inst (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req),
    .use_ss(use_ss), .power_down_pin(pd_pin), .slave_select_pin(ss_pin));
  ulp_mode_control ulp_mode_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_down_pin(pd_pin), .slave_select_pin(ss_pin),
    .alarm_event(alarm), .osc_fail_event(osc), .port_pins(pins), .regulator_enable(reg_en),
    .low_power_mode(lp_mode), .irq(irq));

  // Free-running 100 MHz clock
  always #5 pclk = ~pclk;

  // Case-equality compare so an unknown never passes
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask

  // One APB transfer; waits for pready as long as it takes, the watchdog ends a hang
  task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [9:0] idx, input logic [31:0] exp, input string name);
    apb(1'b0, idx, 32'h0);
    chk(name, exp, rdata);
  endtask

  task tally_and_finish;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog: the whole run needs only a few hundred cycles
  initial
  begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    rows = '{'{0, 1, 0, 0, 8'h01, 8'h01, 0, 0, 3'h1}, '{1, 1, 0, 0, 8'h80, 8'h7F, 0, 0, 3'h1},
      '{0, 1, 0, 0, 8'h01, 8'hFE, 0, 0, 3'h0}, '{0, 0, 0, 0, 8'hFF, 8'hFF, 0, 0, 3'h0},
      '{0, 0, 0, 0, 8'h00, 8'h00, 1, 0, 3'h2}, '{0, 0, 0, 1, 8'h00, 8'h00, 0, 1, 3'h4},
      '{0, 0, 1, 0, 8'h00, 8'h00, 1, 1, 3'h0}, '{0, 0, 0, 0, 8'h00, 8'h00, 1, 1, 3'h6}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset_power", 2'b01, {lp_mode, reg_en});
    rd(IDX_LP_CONTROL, 32'h0, "lpc_reset");
    rd(IDX_WAKE_STATUS, 32'h0, "status_reset");
    apb(1'b1, IDX_WAKE_STATUS, 32'hFFFFFFFF);
    rd(IDX_WAKE_STATUS, 32'h0, "status_ro");
    apb(1'b1, IDX_LP_CONTROL, 32'hFFFFFFFF);
    rd(IDX_LP_CONTROL, {24'h0, LPC_WRITE_MASK}, "lpc_bits");
    apb(1'b0, 10'h3FF, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_rd", 32'h0, rdata);
    // Table cases: one wake source or none per row, except the last two rows with both alarm and oscillator failure, disabled in the first
    foreach (rows[i])
    begin
      r = rows[i];
      idle = r.pol ? 8'hFF : 8'h00;
      pins <= idle;
      use_ss <= r.ss;
      apb(1'b1, IDX_INT_STATUS, 32'h3);
      apb(1'b1, IDX_MASTER_CONTROL, 32'h40);
      apb(1'b1, IDX_PM_MASK, {24'h0, r.mask});
      apb(1'b1, IDX_LP_CONTROL, {27'h0, r.dis, 3'h0, r.pol});
      apb(1'b1, IDX_LP_CONTROL, {27'h0, r.dis, 2'h0, r.en, r.pol});
      sleep_req <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("enter", 2'b10, {lp_mode, reg_en});
      pins <= r.pins;
      alarm <= r.al;
      osc <= r.of;
      repeat (4) @(posedge pclk);
      chk("stay_low", {31'h0, r.exp == 3'h0}, {31'h0, lp_mode});
      pins <= idle;
      alarm <= 1'b0;
      osc <= 1'b0;
      sleep_req <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("wake", 2'b01, {lp_mode, reg_en});
      rd(IDX_WAKE_STATUS, {29'h0, r.exp}, "status");
      rd(IDX_LP_CONTROL, {27'h0, r.dis, 3'h0, r.pol}, "pm_en");
    end
    // Pending wake event blocks entry and keeps the interrupt up
    apb(1'b1, IDX_INT_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    sleep_req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("refused", 3'b011, {lp_mode, reg_en, irq});
    rd(IDX_INT_STATUS, 32'h3, "int_refused");
    sleep_req <= 1'b0;
    apb(1'b1, IDX_INT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, IDX_INT_STATUS, 32'h3);
    rd(IDX_INT_STATUS, 32'h0, "int_clear");
    // Status clear action, then mask clear action
    rd(IDX_WAKE_STATUS, 32'h6, "status_held");
    apb(1'b1, IDX_MASTER_CONTROL, 32'h40);
    rd(IDX_WAKE_STATUS, 32'h0, "status_clear");
    apb(1'b1, IDX_PM_MASK, 32'hFF);
    apb(1'b1, IDX_MASTER_CONTROL, 32'h2);
    rd(IDX_PM_MASK, 32'h0, "mask_clear");
    // Mid-run reset out of low power: normal mode and control register back at reset
    apb(1'b1, IDX_LP_CONTROL, 32'h8);
    sleep_req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("lp_before_reset", 2'b10, {lp_mode, reg_en});
    presetn <= 1'b0;
    sleep_req <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("rerun_power", 2'b01, {lp_mode, reg_en});
    rd(IDX_LP_CONTROL, 32'h0, "lpc_rerun");
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- sim/ulp_host_model.sv
// Host-side model that drives the power-down and slave-select pins.
// Assumes requests arrive from the bench synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
module ulp_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_req,
  input wire logic use_ss,
  output logic power_down_pin,
  output logic slave_select_pin
);
  // One pin carries the request; the other rests low so it never adds an edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_down_pin <= 1'b0;
      slave_select_pin <= 1'b0;
    end
    else
    begin
      power_down_pin <= sleep_req & ~use_ss;
      slave_select_pin <= sleep_req & use_ss;
    end
  end
endmodule
`default_nettype wire
